//--- common/peehc_pkg.sv
package peehc_pkg;

  // ==========================================================
  // geometry
  localparam int ADDR_W       = 13;
  localparam int DATA_W       = 8;
  localparam int PAGE_BYTES   = 64;
  localparam int PAGE_LSB     = 6;

  // ==========================================================
  // timing, printed figures and derived cycle counts at 200 MHz
  localparam int CLK_PERIOD_PS      = 5000;
  localparam int READ_ACCESS_NS     = 350;
  localparam int WE_PULSE_NS        = 100;
  localparam int WE_HIGH_NS         = 200;
  localparam int ADDR_HOLD_NS       = 150;
  localparam int OE_SETUP_NS        = 10;
  localparam int OE_HIGH_BUS_NS     = 50;
  localparam int BYTE_LOAD_MAX_US   = 100;
  localparam int WRITE_CYCLE_MAX_MS = 10;
  localparam int PWR_READ_US        = 100;
  localparam int PWR_WRITE_MS       = 5;

  localparam int READ_CYC  = (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;
  localparam int WE_LOW_CYC  = (WE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;
  localparam int WE_HIGH_CYC = (WE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;
  localparam int SETUP_CYC   = (OE_SETUP_NS * 1000 + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;
  localparam int TURN_CYC    = (OE_HIGH_BUS_NS * 1000 + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;
  localparam int HOLD_CYC    = (ADDR_HOLD_NS * 1000 + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;
  // longest time rounds down
  localparam int BYTE_LOAD_CYC = BYTE_LOAD_MAX_US * 1000000 / CLK_PERIOD_PS;
  localparam int WRITE_MAX_CYC = WRITE_CYCLE_MAX_MS * 200000;
  localparam int PWR_READ_CYC  = PWR_READ_US * 200;
  localparam int PWR_WRITE_CYC = PWR_WRITE_MS * 200000;

  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;

endpackage

//--- core/peehc_host.sv
module peehc_host #(
  parameter int PWR_READ_CYC  = peehc_pkg::PWR_READ_CYC,
  parameter int PWR_WRITE_CYC = peehc_pkg::PWR_WRITE_CYC,
  parameter int BYTE_LOAD_CYC = peehc_pkg::BYTE_LOAD_CYC,
  parameter int WRITE_MAX_CYC = peehc_pkg::WRITE_MAX_CYC
) (
  input  wire logic                           clock,
  input  wire logic                           reset_n,
  // user side
  input  wire logic                           req_valid,
  output logic                                req_ready,
  input  wire logic                           req_write,
  input  wire logic                           req_last,
  input  wire logic [peehc_pkg::ADDR_W-1:0]   req_addr,
  input  wire logic [peehc_pkg::DATA_W-1:0]   req_data,
  output logic                                rsp_valid,
  output logic [peehc_pkg::DATA_W-1:0]        rsp_data,
  output logic                                busy,
  output logic                                page_error,
  output logic                                write_timeout,
  // device pins
  output logic [peehc_pkg::ADDR_W-1:0]        address_lines,
  output logic                                chip_select_n,
  output logic                                output_drive_n,
  output logic                                write_strobe_n,
  input  wire logic [peehc_pkg::DATA_W-1:0]   data_lines_in,
  output logic [peehc_pkg::DATA_W-1:0]        data_lines_out,
  output logic                                data_lines_oe_n
);

  // ==========================================================
  // state
  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,
    S_RSET  = 8'h02,
    S_READ  = 8'h04,
    S_TURN  = 8'h08,
    S_WLOW  = 8'h10,
    S_WHIGH = 8'h20,
    S_POLL  = 8'h40,
    S_PTURN = 8'h80
  } peehc_state_t;

  typedef struct packed {
    peehc_state_t                       st;
    logic [peehc_pkg::CNT_W-1:0]        cnt;
    logic [peehc_pkg::CNT_W-1:0]        pwr;
    logic [peehc_pkg::CNT_W-1:0]        wait_cnt;
    logic                               page_open;
    logic                               prog;
    logic [peehc_pkg::ADDR_W-1:0]       page_addr;
    logic [peehc_pkg::ADDR_W-1:0]       last_addr;
    logic [peehc_pkg::DATA_W-1:0]       last_data;
    logic [6:0]                         page_cnt;
    logic                               last_byte;
    logic                               poll_first;
    logic [peehc_pkg::DATA_W-1:0]       poll_prev;
    logic                               rsp_valid;
    logic [peehc_pkg::DATA_W-1:0]       rsp_data;
    logic                               page_error;
    logic                               write_timeout;
    logic [peehc_pkg::ADDR_W-1:0]       addr;
    logic [peehc_pkg::DATA_W-1:0]       dout;
    logic                               cs_n;
    logic                               oe_n;
    logic                               we_n;
    logic                               bus_oe_n;
  } peehc_regs_t;

  peehc_regs_t r;
  peehc_regs_t next_r;

  function automatic logic [peehc_pkg::CNT_W-1:0] dec(
    input logic [peehc_pkg::CNT_W-1:0] v);
    dec = (v == peehc_pkg::CNT_ZERO) ? v : v - 24'h000001;
  endfunction

  function automatic logic same_page(
    input logic [peehc_pkg::ADDR_W-1:0] a,
    input logic [peehc_pkg::ADDR_W-1:0] b);
    same_page = a[peehc_pkg::ADDR_W-1:peehc_pkg::PAGE_LSB] ==
                b[peehc_pkg::ADDR_W-1:peehc_pkg::PAGE_LSB];
  endfunction

  logic can_read;
  logic can_write;
  logic page_ok;
  logic load_closing;

  assign can_read  = (r.pwr <= 24'(PWR_WRITE_CYC - PWR_READ_CYC));
  assign can_write = (r.pwr == peehc_pkg::CNT_ZERO);
  assign page_ok   = !r.page_open || (same_page(req_addr, r.page_addr) &&
                     r.page_cnt < 7'(peehc_pkg::PAGE_BYTES));
  // no take once the load window is about to lapse
  assign load_closing = r.page_open &&
                        (r.wait_cnt <= 24'(peehc_pkg::SETUP_CYC + 3));
  // reads wait until the page is stored, else status comes back
  assign req_ready = (r.st == S_IDLE) && !r.prog && !load_closing &&
                     (req_write ? can_write && page_ok :
                      can_read && !r.page_open);

  always_comb
  begin
    next_r = r;
    next_r.rsp_valid = 1'b0;
    next_r.cnt = dec(r.cnt);
    next_r.pwr = dec(r.pwr);
    next_r.wait_cnt = dec(r.wait_cnt);
    // device closes page when the byte load window lapses
    if (r.page_open && r.wait_cnt == peehc_pkg::CNT_ZERO)
    begin
      next_r.page_open = 1'b0;
      next_r.prog = 1'b1;
      next_r.poll_first = 1'b1;
      next_r.wait_cnt = 24'(WRITE_MAX_CYC);
    end
    unique case (r.st)
      S_IDLE:
      begin
        if (r.prog && r.cnt == peehc_pkg::CNT_ZERO)
        begin
          next_r.st = S_POLL;
          next_r.addr = r.last_addr;
          next_r.cs_n = 1'b0;
          next_r.oe_n = 1'b0;
          next_r.cnt = 24'(peehc_pkg::READ_CYC);
        end
        else if (req_valid && req_ready && !req_write)
        begin
          next_r.st = S_READ;
          next_r.addr = req_addr;
          next_r.cs_n = 1'b0;
          next_r.oe_n = 1'b0;
          next_r.cnt = 24'(peehc_pkg::READ_CYC);
        end
        else if (req_valid && req_ready)
        begin
          // page address fixed by first byte
          if (!r.page_open)
          begin
            next_r.page_addr = req_addr;
            next_r.page_cnt = 7'h00;
          end
          next_r.st = S_RSET;
          next_r.addr = req_addr;
          next_r.dout = req_data;
          next_r.bus_oe_n = 1'b0;
          next_r.cs_n = 1'b0;
          next_r.cnt = 24'(peehc_pkg::SETUP_CYC);
          next_r.last_addr = req_addr;
          next_r.last_data = req_data;
          next_r.last_byte = req_last;
          next_r.page_open = 1'b1;
          next_r.wait_cnt = 24'(BYTE_LOAD_CYC);
        end
        else if (req_valid && req_write && r.page_open && !page_ok)
          next_r.page_error = 1'b1;
      end
      S_RSET:
        if (r.cnt == peehc_pkg::CNT_ZERO)
        begin
          // strobe controlled write, one strobe per byte
          next_r.st = S_WLOW;
          next_r.we_n = 1'b0;
          next_r.wait_cnt = 24'(BYTE_LOAD_CYC);
          next_r.cnt = 24'(peehc_pkg::WE_LOW_CYC + peehc_pkg::HOLD_CYC);
        end
      S_WLOW:
        if (r.cnt == peehc_pkg::CNT_ZERO)
        begin
          next_r.st = S_WHIGH;
          next_r.we_n = 1'b1;
          next_r.cs_n = 1'b1;
          next_r.page_cnt = r.page_cnt + 7'h01;
          next_r.cnt = 24'(peehc_pkg::WE_HIGH_CYC);
        end
      S_WHIGH:
        if (r.cnt == peehc_pkg::CNT_ZERO)
        begin
          next_r.st = S_IDLE;
          next_r.bus_oe_n = 1'b1;
          // drive stays high between loads, no foreign fetch
          // last byte or full page closes the load early
          if (r.last_byte || r.page_cnt == 7'(peehc_pkg::PAGE_BYTES))
            next_r.wait_cnt = peehc_pkg::CNT_ZERO;
        end
      S_READ, S_POLL:
        if (r.cnt == peehc_pkg::CNT_ZERO)
        begin
          next_r.st = (r.st == S_READ) ? S_TURN : S_PTURN;
          next_r.cs_n = 1'b1;
          next_r.oe_n = 1'b1;
          next_r.cnt = 24'(peehc_pkg::TURN_CYC);
          if (r.st == S_READ)
          begin
            next_r.rsp_valid = 1'b1;
            next_r.rsp_data = data_lines_in;
          end
          else
          begin
            next_r.poll_first = 1'b0;
            next_r.poll_prev = data_lines_in;
            // done when top bit true and bit six steady
            if (!r.poll_first &&
                data_lines_in[7] == r.last_data[7] &&
                data_lines_in[6] == r.poll_prev[6])
              next_r.prog = 1'b0;
          end
        end
      S_TURN, S_PTURN:
        if (r.cnt == peehc_pkg::CNT_ZERO)
          next_r.st = S_IDLE;
      default:
        next_r.st = S_IDLE;
    endcase
    // give up polling after the longest write time
    if (r.prog && !r.page_open && r.wait_cnt == peehc_pkg::CNT_ZERO &&
        next_r.prog)
    begin
      next_r.prog = 1'b0;
      next_r.write_timeout = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r <= '0;
      r.st <= S_IDLE;
      r.pwr <= 24'(PWR_WRITE_CYC);
      r.cs_n <= 1'b1;
      r.oe_n <= 1'b1;
      r.we_n <= 1'b1;
      r.bus_oe_n <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign rsp_valid       = r.rsp_valid;
  assign rsp_data        = r.rsp_data;
  assign busy            = r.prog || r.page_open || (r.st != S_IDLE);
  assign page_error      = r.page_error;
  assign write_timeout   = r.write_timeout;
  assign address_lines   = r.addr;
  assign chip_select_n   = r.cs_n;
  assign output_drive_n  = r.oe_n;
  assign write_strobe_n  = r.we_n;
  assign data_lines_out  = r.dout;
  assign data_lines_oe_n = r.bus_oe_n;

endmodule

//--- testbench/peehc_host_props.sv
module peehc_host_props #(
  parameter int PWR_READ_CYC  = 20,
  parameter int PWR_WRITE_CYC = 40
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_write,
  input wire logic rsp_valid,
  input wire logic chip_select_n,
  input wire logic output_drive_n,
  input wire logic write_strobe_n,
  input wire logic data_lines_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [23:0] up;
  // ==========================================
  // saturating age, slack of two for the launch edge
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      up <= 24'h000000;
    else if (~&up)
      up <= up + 24'h000001;
  sequence s_low_20; !write_strobe_n throughout (1 ##19 1); endsequence
  sequence s_high_40; write_strobe_n throughout (1 ##39 1); endsequence
  property p_rd; !output_drive_n |-> write_strobe_n && data_lines_oe_n;
  endproperty
  property p_wr; !write_strobe_n |->
    !chip_select_n && output_drive_n && !data_lines_oe_n; endproperty
  property p_we_low; $fell(write_strobe_n) |-> s_low_20; endproperty
  property p_we_high; $rose(write_strobe_n) |-> s_high_40; endproperty
  property p_oe_set; $fell(write_strobe_n) |-> $past(output_drive_n, 2);
  endproperty
  property p_pwr_rd; !chip_select_n |-> up + 2 >= PWR_READ_CYC; endproperty
  property p_pwr_wr; !write_strobe_n |-> up + 2 >= PWR_WRITE_CYC; endproperty
  property p_rsp; req_valid && req_ready && !req_write |->
    ##[70:74] rsp_valid; endproperty
  a_rd: assert property (p_rd) else $error("read mode");
  a_wr: assert property (p_wr) else $error("write mode");
  a_we_low: assert property (p_we_low) else $error("strobe short");
  a_we_high: assert property (p_we_high) else $error("strobe gap");
  a_oe_set: assert property (p_oe_set) else $error("drive setup");
  a_pwr_rd: assert property (p_pwr_rd) else $error("early read");
  a_pwr_wr: assert property (p_pwr_wr) else $error("early write");
  a_rsp: assert property (p_rsp) else $error("read answer");
endmodule

bind peehc_host peehc_host_props #(.PWR_READ_CYC(PWR_READ_CYC),
  .PWR_WRITE_CYC(PWR_WRITE_CYC)) props_i (.clock, .reset_n, .req_valid,
  .req_ready, .req_write, .rsp_valid, .chip_select_n, .output_drive_n,
  .write_strobe_n, .data_lines_oe_n);

//--- testbench/peehc_dev_model.sv
module peehc_dev_model #(
  parameter int LOAD_CYC = 200,
  parameter int PROG_CYC = 600
) (
  input  wire logic        clock,
  input  wire logic [12:0] address_lines,
  input  wire logic        chip_select_n,
  input  wire logic        output_drive_n,
  input  wire logic        write_strobe_n,
  input  wire logic [7:0]  data_lines_out,
  input  wire logic        data_lines_oe_n,
  output logic      [7:0]  data_lines_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  mem [8192];
  logic [7:0]  pd [64];
  logic [63:0] pm = 64'h0;
  logic [6:0]  pp;
  logic [5:0]  la;
  logic [7:0]  ld, junk = 8'h5a;
  logic        open = 0, prog = 0, tog = 0, we_q = 1, oe_q = 1;
  int          t = 0;
  // ==========================================
  // pins sampled mid-cycle, away from the host's launch edge
  always @(negedge clock)
  begin
    junk <= junk + 8'h5b;
    we_q <= write_strobe_n;
    oe_q <= output_drive_n;
    t <= t + 1;
    if (we_q && !write_strobe_n && !chip_select_n && output_drive_n && !prog)
    begin
      open <= 1'b1;
      t <= 0;
      pp <= address_lines[12:6];
      la <= address_lines[5:0];
    end
    if (!we_q && write_strobe_n && open)
    begin
      pd[la] <= data_lines_out;
      pm[la] <= 1'b1;
      ld <= data_lines_out;
    end
    if (open && t == LOAD_CYC)
    begin
      open <= 1'b0;
      prog <= 1'b1;
      pm <= 64'h0;
      for (int i = 0; i < 64; i++)
        if (pm[i])
          mem[{pp, 6'(i)}] = pd[i];
    end
    if (prog && t == PROG_CYC)
      prog <= 1'b0;
    if (oe_q && !output_drive_n && !chip_select_n && (open || prog))
      tog <= ~tog;
  end
  // protection option left disabled, writes open except while programming
  // drive only when selected, status while busy
  always_comb
    if (!data_lines_oe_n)
      data_lines_in = data_lines_out;
    else if (chip_select_n || output_drive_n)
      data_lines_in = junk;
    else if (open || prog)
      data_lines_in = {~ld[7], tog, ld[5:0]};
    else
      data_lines_in = mem[address_lines];
endmodule

//--- testbench/peehc_host_tb.sv
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("unexpected at %0t got %h exp %h", $time, a, b); end end
module peehc_host_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock = 0, reset_n, req_valid, req_write, req_last;
  logic [12:0] req_addr, address_lines;
  logic [7:0]  req_data, rsp_data, data_lines_in, data_lines_out, e;
  logic        req_ready, rsp_valid, busy, page_error, write_timeout;
  logic        chip_select_n, output_drive_n, write_strobe_n, data_lines_oe_n;
  logic [7:0]  em [8192];
  logic [7:0]  q [$];
  int          seed = 15778, fails = 0, check_count = 0, k;
  peehc_host #(.PWR_READ_CYC(20), .PWR_WRITE_CYC(40), .BYTE_LOAD_CYC(200),
    .WRITE_MAX_CYC(2000)) peehc_host_i (.clock, .reset_n, .req_valid,
    .req_ready, .req_write, .req_last, .req_addr, .req_data, .rsp_valid,
    .rsp_data, .busy, .page_error, .write_timeout, .address_lines,
    .chip_select_n, .output_drive_n, .write_strobe_n, .data_lines_in,
    .data_lines_out, .data_lines_oe_n);
  peehc_dev_model peehc_dev_model_i (.clock, .address_lines, .chip_select_n,
    .output_drive_n, .write_strobe_n, .data_lines_out, .data_lines_oe_n,
    .data_lines_in);
  always #2.5 clock = ~clock;
  always @(negedge clock)
    if (rsp_valid === 1'b1)
    begin
      e = q.pop_front();
      `CHK(rsp_data, e)
    end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic req(input logic w, l, input logic [12:0] a, logic [7:0] d);
    @(posedge clock);
    {req_valid, req_write, req_last} <= {1'b1, w, l};
    {req_addr, req_data} <= {a, d};
    @(negedge clock);
    for (k = 0; k < 6000 && req_ready !== 1'b1; k++)
      @(negedge clock);
    if (k == 6000)
    begin
      fails++;
      stop_test();
    end
    @(posedge clock);
    req_valid <= 1'b0;
  endtask
  task automatic wr(input logic [12:0] a, input logic l);
    em[a] = 8'($random(seed));
    req(1'b1, l, a, em[a]);
  endtask
  task automatic rd(input logic [12:0] a);
    q.push_back(em[a]);
    req(1'b0, 1'b0, a, 8'h00);
  endtask
  initial
  begin
    {reset_n, req_valid, req_write, req_last, req_addr, req_data} = 0;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    // page closed by its last byte
    for (int i = 0; i < 3; i++)
      wr(13'h0040 + 13'(i), i == 2);
    for (int i = 0; i < 3; i++)
      rd(13'h0040 + 13'(i));
    $display("test 1 done");
    // full page of 64 closes itself
    for (int i = 0; i < 64; i++)
      wr(13'h0080 + 13'(i), 1'b0);
    rd(13'h0080);
    rd(13'h00bf);
    $display("test 2 done");
    // open page, other page refused, window closes it
    wr(13'h0101, 1'b0);
    @(posedge clock);
    {req_valid, req_write, req_addr} <= {1'b1, 1'b1, 13'h0140};
    for (k = 0; k < 150 && page_error !== 1'b1; k++)
      @(negedge clock);
    `CHK(page_error, 1'b1)
    `CHK(req_ready, 1'b0)
    @(posedge clock);
    req_valid <= 1'b0;
    rd(13'h0101);
    rd(13'h0041);
    $display("test 3 done");
    for (k = 0; k < 6000 && (busy !== 1'b0 || q.size() != 0); k++)
      @(negedge clock);
    `CHK(k < 6000, 1'b1)
    `CHK(write_timeout, 1'b0)
    stop_test();
  end
endmodule
